// ==== level_ctrl.sv ====
`timescale 1ns/1ps
`include "level_ctrl_defs.svh"
module level_ctrl
	import level_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register port from serial control slave
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Video timing, converter samples and level target
	input wire logic hsync_start,
	input wire logic [9:0] blank_sample,
	input wire level_ctrl_pkg::level_t level_target,
	// Level loop outputs
	output logic level_window,
	output level_ctrl_pkg::level_t level_offset,
	output logic level_update,
	// Clamp, power and converter setup controls
	output logic [2:0] fine_clamp_on,
	output logic [1:0] fine_time_const,
	output logic [2:0] coarse_clamp_on,
	output logic [1:0] coarse_charge_current,
	output logic green_sync_clamp_enable,
	output logic [3:0] block_powerdown,
	output logic [2:0] converter_powerdown,
	output logic [7:0] converter_setup_out
);
	import level_ctrl_pkg::*;

	// ==========================================
	// Register file
	reg_byte_t level_loop_reg, next_level_loop_reg;
	reg_byte_t level_filter_coeffs, next_level_filter_coeffs;
	reg_byte_t fine_clamp_ctrl, next_fine_clamp_ctrl;
	reg_byte_t power_down_ctrl, next_power_down_ctrl;
	reg_byte_t converter_setup, next_converter_setup;
	reg_byte_t coarse_clamp_ctrl, next_coarse_clamp_ctrl;
	reg_byte_t green_sync_clamp, next_green_sync_clamp;
	reg_byte_t level_window_delay, next_level_window_delay;
	reg_byte_t next_reg_rdata;

	// ==========================================
	// Register access decode
	function automatic logic wr_hit(input logic [7:0] addr);
		wr_hit = reg_wr && reg_addr == addr;
	endfunction

	function automatic reg_byte_t wr_field(input reg_byte_t cur, input reg_byte_t mask,
		input logic hit);
		// Reserved bits never store, so they always read back as zero
		wr_field = hit ? (reg_wdata & mask) : cur;
	endfunction

	function automatic reg_byte_t read_mux(input logic [7:0] addr);
		unique case (addr)
			`ADDR_LOOP_ENABLE: read_mux = level_loop_reg;
			`ADDR_FILTER_COEFFS: read_mux = level_filter_coeffs;
			`ADDR_FINE_CLAMP: read_mux = fine_clamp_ctrl;
			`ADDR_POWER_DOWN: read_mux = power_down_ctrl;
			`ADDR_CONV_SETUP: read_mux = converter_setup;
			`ADDR_COARSE_CLAMP: read_mux = coarse_clamp_ctrl;
			`ADDR_GREEN_SYNC_CLAMP: read_mux = green_sync_clamp;
			`ADDR_WINDOW_DELAY: read_mux = level_window_delay;
			// Unmapped subaddresses read as zero
			default: read_mux = 8'h00;
		endcase
	endfunction

	// ==========================================
	// Register write and read next values
	always_comb begin
		next_level_loop_reg = wr_field(level_loop_reg, `MASK_LOOP_ENABLE,
			wr_hit(`ADDR_LOOP_ENABLE));
		next_level_filter_coeffs = wr_field(level_filter_coeffs, `MASK_FILTER_COEFFS,
			wr_hit(`ADDR_FILTER_COEFFS));
		next_fine_clamp_ctrl = wr_field(fine_clamp_ctrl, `MASK_FINE_CLAMP,
			wr_hit(`ADDR_FINE_CLAMP));
		next_power_down_ctrl = wr_field(power_down_ctrl, `MASK_POWER_DOWN,
			wr_hit(`ADDR_POWER_DOWN));
		next_converter_setup = wr_field(converter_setup, `MASK_CONV_SETUP,
			wr_hit(`ADDR_CONV_SETUP));
		next_coarse_clamp_ctrl = wr_field(coarse_clamp_ctrl, `MASK_COARSE_CLAMP,
			wr_hit(`ADDR_COARSE_CLAMP));
		next_green_sync_clamp = wr_field(green_sync_clamp, `MASK_GREEN_SYNC_CLAMP,
			wr_hit(`ADDR_GREEN_SYNC_CLAMP));
		next_level_window_delay = wr_field(level_window_delay, `MASK_WINDOW_DELAY,
			wr_hit(`ADDR_WINDOW_DELAY));
		// Read data holds until the next read strobe
		next_reg_rdata = reg_rdata;
		if (reg_rd) begin
			next_reg_rdata = read_mux(reg_addr);
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			level_loop_reg <= `RST_LOOP_ENABLE;
			level_filter_coeffs <= `RST_FILTER_COEFFS;
			fine_clamp_ctrl <= `RST_FINE_CLAMP;
			power_down_ctrl <= `RST_POWER_DOWN;
			converter_setup <= `RST_CONV_SETUP;
			coarse_clamp_ctrl <= `RST_COARSE_CLAMP;
			green_sync_clamp <= `RST_GREEN_SYNC_CLAMP;
			level_window_delay <= `RST_WINDOW_DELAY;
			reg_rdata <= 8'h00;
		end else begin
			level_loop_reg <= next_level_loop_reg;
			level_filter_coeffs <= next_level_filter_coeffs;
			fine_clamp_ctrl <= next_fine_clamp_ctrl;
			power_down_ctrl <= next_power_down_ctrl;
			converter_setup <= next_converter_setup;
			coarse_clamp_ctrl <= next_coarse_clamp_ctrl;
			green_sync_clamp <= next_green_sync_clamp;
			level_window_delay <= next_level_window_delay;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ==========================================
	// Static controls, registered again so every output is a flop
	logic [2:0] next_fine_clamp_on;
	logic [1:0] next_fine_time_const;
	logic [2:0] next_coarse_clamp_on;
	logic [1:0] next_coarse_charge_current;
	logic next_green_sync_clamp_enable;
	logic [3:0] next_block_powerdown;
	logic [2:0] next_converter_powerdown;
	logic [7:0] next_converter_setup_out;

	// Outputs lag their register by one edge; the host cannot see the gap
	always_comb begin
		next_fine_clamp_on = fine_clamp_ctrl[2:0];
		next_fine_time_const = fine_clamp_ctrl[4:3];
		next_coarse_clamp_on = coarse_clamp_ctrl[2:0];
		next_coarse_charge_current = coarse_clamp_ctrl[7:6];
		next_green_sync_clamp_enable = green_sync_clamp[7];
		next_block_powerdown = power_down_ctrl[6:3];
		next_converter_powerdown = power_down_ctrl[2:0];
		next_converter_setup_out = converter_setup;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fine_clamp_on <= 3'h0;
			fine_time_const <= 2'h0;
			coarse_clamp_on <= 3'h0;
			coarse_charge_current <= 2'h0;
			green_sync_clamp_enable <= 1'b0;
			block_powerdown <= 4'h0;
			converter_powerdown <= 3'h0;
			converter_setup_out <= 8'h00;
		end else begin
			fine_clamp_on <= next_fine_clamp_on;
			fine_time_const <= next_fine_time_const;
			coarse_clamp_on <= next_coarse_clamp_on;
			coarse_charge_current <= next_coarse_charge_current;
			green_sync_clamp_enable <= next_green_sync_clamp_enable;
			block_powerdown <= next_block_powerdown;
			converter_powerdown <= next_converter_powerdown;
			converter_setup_out <= next_converter_setup_out;
		end
	end

	// ==========================================
	// Level loop: delay, sample, average, correct
	loop_state_t state, next_state;
	// Both counters reload per line, never free running
	logic [7:0] delay_cnt, next_delay_cnt;
	logic [7:0] sample_cnt, next_sample_cnt;
	logic [16:0] sum, next_sum;
	logic signed [15:0] next_level_offset;
	logic next_level_window, next_level_update;
	logic loop_on;
	logic [2:0] horiz_sample_coeff;
	logic [3:0] vert_correction_coeff;
	logic [7:0] sample_target;
	logic signed [17:0] avg_level, err, step, acc;


	assign loop_on = level_loop_reg[`LOOP_ENABLE_BIT];
	assign horiz_sample_coeff = level_filter_coeffs[`HORIZ_LSB +: 3];
	assign vert_correction_coeff = level_filter_coeffs[`VERT_LSB +: 4];
	assign sample_target = 8'((9'h001 << horiz_sample_coeff) - 9'h001);

	// Saturate rather than wrap, so a large error cannot flip the offset sign
	function automatic level_t sat16(input logic signed [17:0] value);
		if (value > 18'sd32767) begin
			sat16 = 16'sh7fff;
		end else if (value < -18'sd32768) begin
			sat16 = -16'sh8000;
		end else begin
			sat16 = value[15:0];
		end
	endfunction

	// ==========================================
	// Correction arithmetic for the line update
	always_comb begin
		avg_level = 18'(($unsigned(sum) + 17'(blank_sample))
			>> horiz_sample_coeff);
		err = 18'(level_target) - avg_level;
		// Arithmetic shift keeps the sign of a negative error
		step = err >>> vert_correction_coeff;
		acc = 18'(level_offset) + step;
	end

	// ==========================================
	// Loop state machine
	always_comb begin
		next_state = state;
		next_delay_cnt = delay_cnt;
		next_sample_cnt = sample_cnt;
		next_sum = sum;
		next_level_offset = level_offset;
		next_level_window = 1'b0;
		next_level_update = 1'b0;
		if (!loop_on) begin
			// Clearing the enable mid-line drops the line without an update
			next_state = ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					// Sync pulses while busy are ignored, not held until the line ends
					if (hsync_start) begin
						next_state = ST_WAIT;
						next_delay_cnt = level_window_delay;
					end
				end
				ST_WAIT: begin
					// Counting down to zero puts the window D+1 edges after sync
					if (delay_cnt == 8'h00) begin
						next_state = ST_SAMPLE;
						next_sample_cnt = 8'h00;
						next_sum = 17'h00000;
						next_level_window = 1'b1;
					end else begin
						next_delay_cnt = delay_cnt - 8'h01;
					end
				end
				ST_SAMPLE: begin
					next_level_window = 1'b1;
					next_sum = sum + 17'(blank_sample);
					next_sample_cnt = sample_cnt + 8'h01;
					// Last sample joins combinationally, so all N reach the average
					if (sample_cnt == sample_target) begin
						next_level_offset = sat16(acc);
						next_level_update = 1'b1;
						next_level_window = 1'b0;
						next_state = ST_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================
	// Loop registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			delay_cnt <= 8'h00;
			sample_cnt <= 8'h00;
			sum <= 17'h00000;
			level_offset <= 16'sh0000;
			level_window <= 1'b0;
			level_update <= 1'b0;
		end else begin
			state <= next_state;
			delay_cnt <= next_delay_cnt;
			sample_cnt <= next_sample_cnt;
			sum <= next_sum;
			level_offset <= next_level_offset;
			level_window <= next_level_window;
			level_update <= next_level_update;
		end
	end
endmodule

// ==== level_ctrl_defs.svh ====
`ifndef LEVEL_CTRL_DEFS_SVH
`define LEVEL_CTRL_DEFS_SVH
// ==========================================
// Register subaddresses
`define ADDR_LOOP_ENABLE 8'h26
`define ADDR_FILTER_COEFFS 8'h28
`define ADDR_FINE_CLAMP 8'h2a
`define ADDR_POWER_DOWN 8'h2b
`define ADDR_CONV_SETUP 8'h2c
`define ADDR_COARSE_CLAMP 8'h2d
`define ADDR_GREEN_SYNC_CLAMP 8'h2e
`define ADDR_WINDOW_DELAY 8'h31
// ==========================================
// Reset values
`define RST_LOOP_ENABLE 8'h00
`define RST_FILTER_COEFFS 8'h00
`define RST_FINE_CLAMP 8'h00
`define RST_POWER_DOWN 8'h00
`define RST_CONV_SETUP 8'h00
`define RST_COARSE_CLAMP 8'h00
`define RST_GREEN_SYNC_CLAMP 8'h00
`define RST_WINDOW_DELAY 8'h00
// ==========================================
// Field positions and writable masks
`define LOOP_ENABLE_BIT 7
`define HORIZ_LSB 0
`define VERT_LSB 3
`define MASK_LOOP_ENABLE 8'h80
`define MASK_FILTER_COEFFS 8'h7f
`define MASK_FINE_CLAMP 8'h1f
`define MASK_POWER_DOWN 8'h7f
`define MASK_CONV_SETUP 8'hff
`define MASK_COARSE_CLAMP 8'hc7
`define MASK_GREEN_SYNC_CLAMP 8'h80
`define MASK_WINDOW_DELAY 8'hff
`endif

// ==== level_ctrl_pkg.sv ====
package level_ctrl_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic signed [15:0] level_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_SAMPLE = 3'b100
	} loop_state_t;
endpackage

// ==== level_ctrl_properties.sv ====
`timescale 1ns/1ps
module level_ctrl_properties (
	// Clock and register writes
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	// Loop and static outputs
	input wire logic level_window,
	input wire logic level_update,
	input wire logic signed [15:0] level_offset,
	input wire logic [2:0] fine_clamp_on,
	input wire logic [1:0] fine_time_const,
	input wire logic [2:0] coarse_clamp_on,
	input wire logic [1:0] coarse_charge_current,
	input wire logic green_sync_clamp_enable,
	input wire logic [3:0] block_powerdown,
	input wire logic [2:0] converter_powerdown
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// Static controls
	fine_on_a: assert property (reg_wr && reg_addr == 8'h2a |-> ##2
		fine_clamp_on == $past(reg_wdata[2:0], 2)) else $error("fine enables wrong");
	fine_tc_a: assert property (reg_wr && reg_addr == 8'h2a |-> ##2
		fine_time_const == $past(reg_wdata[4:3], 2)) else $error("fine constant wrong");
	coarse_on_a: assert property (reg_wr && reg_addr == 8'h2d |-> ##2
		coarse_clamp_on == $past(reg_wdata[2:0], 2)) else $error("coarse enables wrong");
	coarse_cur_a: assert property (reg_wr && reg_addr == 8'h2d |-> ##2
		coarse_charge_current == $past(reg_wdata[7:6], 2)) else $error("coarse current wrong");
	green_en_a: assert property (reg_wr && reg_addr == 8'h2e |-> ##2
		green_sync_clamp_enable == $past(reg_wdata[7], 2)) else $error("green clamp wrong");
	block_pd_a: assert property (reg_wr && reg_addr == 8'h2b |-> ##2
		block_powerdown == $past(reg_wdata[6:3], 2)) else $error("block powerdown wrong");
	conv_pd_a: assert property (reg_wr && reg_addr == 8'h2b |-> ##2
		converter_powerdown == $past(reg_wdata[2:0], 2)) else $error("converter pd wrong");
	// ==========================================
	// Level loop
	reset_clear_a: assert property (disable iff (1'b0) sys_rst |=>
		level_offset == 16'sh0000 && !level_window) else $error("reset state wrong");
	update_pulse_a: assert property (level_update |->
		!level_window && $past(level_window) ##1 !level_update) else $error("update pulse wrong");
	offset_hold_a: assert property ($changed(level_offset) |-> level_update)
		else $error("offset moved without update");
	cover property (reg_wr && reg_addr == 8'h2a);
	cover property ($rose(level_window));
	cover property (level_update);
endmodule
bind level_ctrl level_ctrl_properties u_props (.clock, .sys_rst, .reg_addr, .reg_wr,
	.reg_wdata, .level_window, .level_update, .level_offset, .fine_clamp_on, .fine_time_const,
	.coarse_clamp_on,
	.coarse_charge_current, .green_sync_clamp_enable, .block_powerdown, .converter_powerdown);

// ==== host_model.sv ====
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic clock,
	// Register port
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		// Stale data must not look valid
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		@(negedge clock);
		d = reg_rdata;
	endtask
	task automatic init();
		wr(8'h2c, 8'h50);
		wr(8'h31, 8'h18);
		wr(8'h2e, 8'h80);
	endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import level_ctrl_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic hsync_start = 1'b0;
	logic [9:0] blank_sample = 10'h028;
	logic signed [15:0] level_target = 16'sh0064;
	wire logic [7:0] reg_addr, reg_wdata, reg_rdata, converter_setup_out;
	wire logic reg_wr, reg_rd, level_window, level_update, green_sync_clamp_enable;
	wire logic signed [15:0] level_offset;
	wire logic [2:0] fine_clamp_on, coarse_clamp_on, converter_powerdown;
	wire logic [1:0] fine_time_const, coarse_charge_current;
	wire logic [3:0] block_powerdown;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int n, first, wide;
	reg_byte_t d;
	reg_byte_t addrs [9] = '{8'h26, 8'h28, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h31, 8'h27};
	reg_byte_t masks [9] = '{8'h80, 8'h7f, 8'h1f, 8'h7f, 8'hff, 8'hc7, 8'h80, 8'hff, 8'h00};
	always #25 clock = ~clock;
	host_model u_host (.clock, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
	level_ctrl u_dut (.clock, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
		.hsync_start, .blank_sample, .level_target, .level_window, .level_offset,
		.level_update, .fine_clamp_on, .fine_time_const, .coarse_clamp_on,
		.coarse_charge_current, .green_sync_clamp_enable, .block_powerdown,
		.converter_powerdown, .converter_setup_out);
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (n_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			end_of_test();
		end
	end
	// One video line: note when the window opens and how long it stays
	task automatic line();
		@(negedge clock);
		hsync_start = 1'b1;
		@(negedge clock);
		hsync_start = 1'b0;
		n = 0;
		first = 0;
		wide = 0;
		while (!level_update && n < 300) begin
			if (level_window && first == 0)
				first = n;
			if (level_window)
				wide++;
			@(negedge clock);
			n++;
		end
	endtask
	initial begin
		repeat (8) @(negedge clock);
		sys_rst = 1'b0;
		foreach (addrs[i]) begin
			u_host.rd(addrs[i], d);
			chk("reset value", d, 0);
		end
		foreach (addrs[i]) begin
			u_host.wr(addrs[i], 8'hff);
			u_host.rd(addrs[i], d);
			chk("write mask", d, masks[i]);
		end
		chk("all controls", {fine_clamp_on, fine_time_const, coarse_clamp_on, coarse_charge_current,
			green_sync_clamp_enable, block_powerdown, converter_powerdown}, 18'h3ffff);
		u_host.wr(8'h2a, 8'h0d);
		u_host.wr(8'h2b, 8'h4a);
		u_host.wr(8'h2d, 8'h45);
		u_host.init();
		u_host.wr(8'h28, 8'h02);
		u_host.wr(8'h26, 8'h80);
		chk("bit map", {fine_clamp_on, fine_time_const, coarse_clamp_on, coarse_charge_current,
			green_sync_clamp_enable, block_powerdown, converter_powerdown}, 18'h2b5ca);
		chk("setup", converter_setup_out, 8'h50);
		line();
		chk("window start", first, 25);
		chk("window width", wide, 4);
		chk("offset full", level_offset, 60);
		level_target = 16'sh0000;
		u_host.wr(8'h28, 8'h0a);
		line();
		chk("offset half", level_offset, 40);
		u_host.wr(8'h28, 8'h7f);
		line();
		chk("window max", wide, 128);
		chk("offset min", level_offset, 39);
		u_host.wr(8'h26, 8'h00);
		line();
		chk("loop off", wide, 0);
		chk("offset kept", level_offset, 39);
		end_of_test();
	end
endmodule
